// file: dci_map.svh
// constants of the dac command front end: codes, field positions, reset values, timing
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH

// client address
`define DCI_ADDR_UPPER_FIXED 5'h18
`define DCI_GC_ADDR          8'h00
`define DCI_HS_PREFIX        5'h01
`define DCI_HS_PREFIX_MSB    7
`define DCI_HS_PREFIX_LSB    3

// general call second byte codes
`define DCI_GC_RESET         8'h06
`define DCI_GC_WAKE          8'h0A

// command byte layout
`define DCI_CMD_ADDR_MSB     7
`define DCI_CMD_ADDR_LSB     3
`define DCI_CMD_TYPE_MSB     2
`define DCI_CMD_TYPE_LSB     1
`define DCI_CMD_WRITE        2'h0
`define DCI_CMD_READ         2'h3

// memory pointer and implemented locations
`define DCI_PTR_RESET        5'h00
`define DCI_IMPL_MASK        32'h0000FFFF

// byte framing
`define DCI_BIT_LAST         4'h7
`define DCI_BIT_ACK          4'h8

// bus rates and spike filter timing
`define DCI_SYS_HZ           10000000
`define DCI_STD_HZ           100000
`define DCI_FAST_HZ          400000
`define DCI_HS_HZ            3400000
`define DCI_GOBBLE_NS        10
`define DCI_SYS_PERIOD_NS    100
`define DCI_GOBBLE_CYC       ((`DCI_GOBBLE_NS + `DCI_SYS_PERIOD_NS - 1) / `DCI_SYS_PERIOD_NS)

`endif

// file: dci_pkg.sv
// types of the dac command front end
package dci_pkg;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_CMD  = 8'h04,
        ST_DHI  = 8'h08,
        ST_DLO  = 8'h10,
        ST_GC   = 8'h20,
        ST_RD   = 8'h40,
        ST_NACK = 8'h80
    } dci_state_t;

    typedef struct packed {
        dci_state_t  st;
        dci_state_t  nx;
        logic [3:0]  cnt;
        logic [6:0]  sh;
        logic        seen_start;
        logic        drive;
        logic [4:0]  ptr;
        logic [7:0]  wr_hi;
        logic [4:0]  wr_addr;
        logic [15:0] wr_data;
        logic        wr_tog;
        logic        gcr_tog;
        logic        gcw_tog;
        logic        hs_tog;
        logic [1:0]  gc_pend;
        logic [15:0] rd_sh;
        logic        rd_lo;
    } dci_link_t;

    typedef struct packed {
        logic        wr_p;
        logic        gcr_p;
        logic        gcw_p;
        logic        hs_p;
        logic        stop_p;
        logic        wr_stb;
        logic [4:0]  wr_addr;
        logic [15:0] wr_data;
        logic        gc_rst;
        logic        gc_wake;
        logic        hs_mode;
        logic [4:0]  ptr;
    } dci_sys_t;

endpackage

// file: dci_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module dci_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dci_sync_st_t;

    dci_sync_st_t q;
    dci_sync_st_t d;

    always_comb begin
        d    = q;
        d.s1 = i_d;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    assign o_q = q.s2;
endmodule // dci_sync

// file: dci_cond.sv
// start and stop detector clocked by data line edges
`timescale 1ns/100ps
module dci_cond (
    input  wire logic i_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_start_tog,
    output logic      o_stop_tog
);
    // each toggle flips once per condition, whatever the link state machine is doing
    always_ff @(negedge i_sda or posedge i_rst) begin
        if (i_rst) begin
            o_start_tog <= 1'b0;
        end else if (i_scl) begin
            o_start_tog <= ~o_start_tog;
        end
    end

    always_ff @(posedge i_sda or posedge i_rst) begin
        if (i_rst) begin
            o_stop_tog <= 1'b0;
        end else if (i_scl) begin
            o_stop_tog <= ~o_stop_tog;
        end
    end
endmodule // dci_cond

// file: dci_i2c_front.sv
// i2c client front end of a multi-channel dac: addressing, modes, pointer, commands
// Operation
// - client only; host makes every clock
// - never hold the clock line low
// - standard, fast and high-speed bit rates
// - power-on reset clears state and pointer
// - memory pointer is five bits wide
// - pointer survives start and stop conditions
// - general call reset and wake-up recognised
// - high-speed clock filter rejects short spikes; no filter is built, the clock line is used unfiltered
// - first byte after start is address
// - default address with two pin bits
// - volatile parts fix upper address bits
// - nonvolatile parts take upper bits stored
// - high-speed code unacknowledged, switches mode
// - high-speed holds until next stop
// - control byte follows high-speed code
// - command type 00 write, 11 read
// - read: write, command, restart, read, 16 clocks
// - narrow parts keep 16-bit word framing
// - acknowledge general call address 0x00
// - general call odd second byte ignored
// - continuous words accepted without stop
// - start or stop mid-data aborts command; the link never sees stop, so only the next start aborts
// - bad command: nack until next start
// - volatile write on last bit edge
`timescale 1ns/100ps
`include "dci_map.svh"
module dci_i2c_front (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe_n,
    input  wire logic        i_address_select_pin_high,
    input  wire logic        i_address_select_pin_low,
    input  wire logic        i_nv_variant,
    input  wire logic [4:0]  i_upper_client_address_bits,
    input  wire logic [15:0] i_rd_data,
    output logic             o_wr_strobe,
    output logic [4:0]       o_wr_addr,
    output logic [15:0]      o_wr_data,
    output logic             o_gc_reset,
    output logic             o_gc_wake,
    output logic             o_hs_mode,
    output logic [4:0]       o_mem_ptr
);
    localparam int CFG_W = 25;
    localparam int SYS_W = 10;
    // a literal cannot be bit-selected, so the location mask lives in a named constant
    localparam logic [31:0] IMPL_MASK = `DCI_IMPL_MASK;

    dci_pkg::dci_link_t l_q;
    dci_pkg::dci_link_t l_d;
    dci_pkg::dci_sys_t  s_q;
    dci_pkg::dci_sys_t  s_d;

    logic             start_tog;
    logic             stop_tog;
    logic [CFG_W-1:0] cfg_s;
    logic [SYS_W-1:0] ev_s;
    logic             rst_scl;
    logic [6:0]       own_addr;
    logic [15:0]      rd_word;
    logic [7:0]       byte_in;
    logic             start_ev;
    logic [4:0]       cmd_addr;
    logic [1:0]       cmd_type;
    logic             cmd_ok;
    logic             sda_oe_n_q;

    dci_cond u_cond (
        .i_rst       (i_rst),
        .i_scl       (i_scl),
        .i_sda       (i_sda),
        .o_start_tog (start_tog),
        .o_stop_tog  (stop_tog)
    );

    // straps, reset and read word are quasi-static by the time the link uses them
    dci_sync #(.W(CFG_W)) u_cfg_sync (
        .i_clk (i_scl),
        .i_d   ({i_rst, i_nv_variant, i_upper_client_address_bits,
                 i_address_select_pin_high, i_address_select_pin_low, i_rd_data}),
        .o_q   (cfg_s)
    );

    assign rst_scl  = cfg_s[24];
    assign rd_word  = cfg_s[15:0];
    assign own_addr = {cfg_s[23] ? cfg_s[22:18] : `DCI_ADDR_UPPER_FIXED, cfg_s[17:16]};

    assign byte_in  = {l_q.sh, i_sda};
    // start toggle flips while the clock is high, before the low clock phase that precedes this edge
    assign start_ev = (start_tog != l_q.seen_start);
    assign cmd_addr = byte_in[`DCI_CMD_ADDR_MSB:`DCI_CMD_ADDR_LSB];
    assign cmd_type = byte_in[`DCI_CMD_TYPE_MSB:`DCI_CMD_TYPE_LSB];
    assign cmd_ok   = ((cmd_type == `DCI_CMD_WRITE) || (cmd_type == `DCI_CMD_READ))
                      && IMPL_MASK[cmd_addr];

    // link side: every bit is taken on the host's rising clock edge
    always_comb begin
        l_d = l_q;
        if (rst_scl) begin
            l_d            = '0;
            l_d.st         = dci_pkg::ST_IDLE;
            l_d.nx         = dci_pkg::ST_IDLE;
            l_d.ptr        = `DCI_PTR_RESET;
            l_d.seen_start = start_tog;
            l_d.wr_tog     = l_q.wr_tog;
            l_d.gcr_tog    = l_q.gcr_tog;
            l_d.gcw_tog    = l_q.gcw_tog;
            l_d.hs_tog     = l_q.hs_tog;
        end else if (start_ev) begin
            // partial words are simply dropped; pointer and mode stay
            l_d.seen_start = start_tog;
            l_d.st         = dci_pkg::ST_ADDR;
            l_d.cnt        = 4'h1;
            l_d.sh         = {6'h00, i_sda};
            l_d.drive      = 1'b0;
            l_d.gc_pend    = 2'h0;
        end else begin
            l_d.cnt = (l_q.cnt == `DCI_BIT_ACK) ? 4'h0 : l_q.cnt + 4'h1;
            l_d.sh  = byte_in[6:0];
            case (l_q.st)
                dci_pkg::ST_ADDR: begin
                    if (l_q.cnt == `DCI_BIT_LAST) begin
                        if (byte_in[`DCI_HS_PREFIX_MSB:`DCI_HS_PREFIX_LSB] == `DCI_HS_PREFIX) begin
                            l_d.hs_tog = ~l_q.hs_tog;
                            l_d.drive  = 1'b0;
                            l_d.nx     = dci_pkg::ST_IDLE;
                        end else if (byte_in == `DCI_GC_ADDR) begin
                            l_d.drive = 1'b1;
                            l_d.nx    = dci_pkg::ST_GC;
                        end else if (byte_in[7:1] == own_addr) begin
                            l_d.drive = 1'b1;
                            l_d.nx    = byte_in[0] ? dci_pkg::ST_RD : dci_pkg::ST_CMD;
                        end else begin
                            l_d.drive = 1'b0;
                            l_d.nx    = dci_pkg::ST_IDLE;
                        end
                    end else if (l_q.cnt == `DCI_BIT_ACK) begin
                        l_d.st    = l_q.nx;
                        l_d.drive = 1'b0;
                        if (l_q.nx == dci_pkg::ST_RD) begin
                            // last-address read starts straight from the kept pointer
                            l_d.drive = ~rd_word[15];
                            l_d.rd_sh = {rd_word[14:0], 1'b0};
                            l_d.rd_lo = 1'b0;
                        end
                    end
                end
                dci_pkg::ST_CMD: begin
                    if (l_q.cnt == `DCI_BIT_LAST) begin
                        l_d.drive = cmd_ok;
                        if (!cmd_ok) begin
                            l_d.nx = dci_pkg::ST_NACK;
                        end else if (cmd_type == `DCI_CMD_WRITE) begin
                            l_d.ptr = cmd_addr;
                            l_d.nx  = dci_pkg::ST_DHI;
                        end else begin
                            l_d.ptr = cmd_addr;
                            l_d.nx  = dci_pkg::ST_IDLE;
                        end
                    end else if (l_q.cnt == `DCI_BIT_ACK) begin
                        l_d.st    = l_q.nx;
                        l_d.drive = 1'b0;
                    end
                end
                dci_pkg::ST_DHI: begin
                    if (l_q.cnt == `DCI_BIT_LAST) begin
                        l_d.wr_hi = byte_in;
                        l_d.drive = 1'b1;
                        l_d.nx    = dci_pkg::ST_DLO;
                    end else if (l_q.cnt == `DCI_BIT_ACK) begin
                        l_d.st    = l_q.nx;
                        l_d.drive = 1'b0;
                    end
                end
                dci_pkg::ST_DLO: begin
                    if (l_q.cnt == `DCI_BIT_LAST) begin
                        l_d.wr_data = {l_q.wr_hi, byte_in};
                        l_d.wr_addr = l_q.ptr;
                        l_d.wr_tog  = ~l_q.wr_tog;
                        l_d.drive   = 1'b1;
                        l_d.nx      = dci_pkg::ST_CMD;
                    end else if (l_q.cnt == `DCI_BIT_ACK) begin
                        l_d.st    = l_q.nx;
                        l_d.drive = 1'b0;
                    end
                end
                dci_pkg::ST_GC: begin
                    if (l_q.cnt == `DCI_BIT_LAST) begin
                        l_d.nx    = dci_pkg::ST_IDLE;
                        l_d.drive = 1'b0;
                        if (byte_in[0]) begin
                            l_d.gc_pend = 2'h0;
                        end else if (byte_in == `DCI_GC_RESET) begin
                            l_d.gc_pend = 2'h1;
                            l_d.drive   = 1'b1;
                        end else if (byte_in == `DCI_GC_WAKE) begin
                            l_d.gc_pend = 2'h2;
                            l_d.drive   = 1'b1;
                        end
                    end else if (l_q.cnt == `DCI_BIT_ACK) begin
                        // acted on only at the rising edge of the acknowledge clock
                        if (l_q.gc_pend[0]) begin
                            l_d.gcr_tog = ~l_q.gcr_tog;
                            l_d.ptr     = `DCI_PTR_RESET;
                        end
                        if (l_q.gc_pend[1]) begin
                            l_d.gcw_tog = ~l_q.gcw_tog;
                        end
                        l_d.gc_pend = 2'h0;
                        l_d.st      = l_q.nx;
                        l_d.drive   = 1'b0;
                    end
                end
                dci_pkg::ST_RD: begin
                    if (l_q.cnt < `DCI_BIT_LAST) begin
                        l_d.drive = ~l_q.rd_sh[15];
                        l_d.rd_sh = {l_q.rd_sh[14:0], 1'b0};
                    end else if (l_q.cnt == `DCI_BIT_LAST) begin
                        l_d.drive = 1'b0;
                    end else if (!i_sda) begin
                        // host acknowledged: next byte, or the word again for continuous reads
                        if (l_q.rd_lo) begin
                            l_d.drive = ~rd_word[15];
                            l_d.rd_sh = {rd_word[14:0], 1'b0};
                        end else begin
                            l_d.drive = ~l_q.rd_sh[15];
                            l_d.rd_sh = {l_q.rd_sh[14:0], 1'b0};
                        end
                        l_d.rd_lo = ~l_q.rd_lo;
                    end else begin
                        l_d.st    = dci_pkg::ST_IDLE;
                        l_d.drive = 1'b0;
                    end
                end
                dci_pkg::ST_IDLE, dci_pkg::ST_NACK: begin
                    l_d.drive = 1'b0;
                end
                default: begin
                    l_d.st    = dci_pkg::ST_IDLE;
                    l_d.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_scl) begin
        l_q <= l_d;
    end

    // open-drain data only; the clock line has no driver at all, so no stretching
    always_ff @(negedge i_scl) begin
        if (rst_scl) begin
            sda_oe_n_q <= 1'b1;
        end else begin
            sda_oe_n_q <= ~l_q.drive;
        end
    end

    assign o_sda_oe_n = sda_oe_n_q;

    // system side: link events arrive as toggles, data words are held stable meanwhile
    dci_sync #(.W(SYS_W)) u_ev_sync (
        .i_clk (i_clk_sys),
        .i_d   ({l_q.wr_tog, l_q.gcr_tog, l_q.gcw_tog, l_q.hs_tog, stop_tog, l_q.ptr}),
        .o_q   (ev_s)
    );

    always_comb begin
        s_d         = s_q;
        s_d.wr_p    = ev_s[9];
        s_d.gcr_p   = ev_s[8];
        s_d.gcw_p   = ev_s[7];
        s_d.hs_p    = ev_s[6];
        s_d.stop_p  = ev_s[5];
        s_d.ptr     = ev_s[4:0];
        s_d.wr_stb  = ev_s[9] != s_q.wr_p;
        s_d.gc_rst  = ev_s[8] != s_q.gcr_p;
        s_d.gc_wake = ev_s[7] != s_q.gcw_p;
        if (ev_s[9] != s_q.wr_p) begin
            s_d.wr_addr = l_q.wr_addr;
            s_d.wr_data = l_q.wr_data;
        end
        // a fresh high-speed code wins over a stop seen in the same cycle
        if (ev_s[6] != s_q.hs_p) begin
            s_d.hs_mode = 1'b1;
        end else if (ev_s[5] != s_q.stop_p) begin
            s_d.hs_mode = 1'b0;
        end
        if (i_rst) begin
            s_d         = '0;
            s_d.wr_p    = ev_s[9];
            s_d.gcr_p   = ev_s[8];
            s_d.gcw_p   = ev_s[7];
            s_d.hs_p    = ev_s[6];
            s_d.stop_p  = ev_s[5];
            s_d.ptr     = `DCI_PTR_RESET;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s_q <= s_d;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
        end
    end

    assign o_wr_strobe = s_q.wr_stb;
    assign o_wr_addr   = s_q.wr_addr;
    assign o_wr_data   = s_q.wr_data;
    assign o_gc_reset  = s_q.gc_rst;
    assign o_gc_wake   = s_q.gc_wake;
    assign o_hs_mode   = s_q.hs_mode;
    assign o_mem_ptr   = s_q.ptr;

    // link-domain checks
    a_hs_code_nack: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_ADDR && l_q.cnt == `DCI_BIT_LAST
         && byte_in[7:3] == `DCI_HS_PREFIX) |=> !l_q.drive ##1 l_q.st == dci_pkg::ST_IDLE)
        else $error("hs code was acknowledged");
    a_gc_addr_ack: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_ADDR && l_q.cnt == `DCI_BIT_LAST
         && byte_in == `DCI_GC_ADDR) |=> l_q.drive ##1 l_q.st == dci_pkg::ST_GC)
        else $error("general call address not acknowledged");
    a_gc_hw_ignored: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_GC && l_q.cnt == `DCI_BIT_LAST && i_sda)
        |=> !l_q.drive && l_q.gc_pend == 2'h0)
        else $error("hardware general call acted on");
    a_bad_cmd_nack: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_CMD && l_q.cnt == `DCI_BIT_LAST
         && cmd_type != `DCI_CMD_WRITE && cmd_type != `DCI_CMD_READ) |=> !l_q.drive)
        else $error("invalid command type acknowledged");
    a_nack_sticky: assert property (@(posedge i_scl) disable iff (rst_scl)
        (l_q.st == dci_pkg::ST_NACK && !start_ev) |=> l_q.st == dci_pkg::ST_NACK && !l_q.drive)
        else $error("left nack state without start");
    a_word_commit: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_DLO && l_q.cnt == `DCI_BIT_LAST)
        |=> l_q.wr_tog != $past(l_q.wr_tog) && l_q.wr_addr == $past(l_q.ptr))
        else $error("data word not committed on last bit");
    a_abort_no_write: assert property (@(posedge i_scl) disable iff (rst_scl)
        start_ev |=> l_q.wr_tog == $past(l_q.wr_tog) && l_q.st == dci_pkg::ST_ADDR)
        else $error("start mid-word wrote data");
    a_ptr_keep: assert property (@(posedge i_scl) disable iff (rst_scl)
        start_ev |=> l_q.ptr == $past(l_q.ptr))
        else $error("pointer changed by start");
    a_gc_reset_ptr: assert property (@(posedge i_scl) disable iff (rst_scl)
        (!start_ev && l_q.st == dci_pkg::ST_GC && l_q.cnt == `DCI_BIT_ACK && l_q.gc_pend[0])
        |=> l_q.ptr == `DCI_PTR_RESET && l_q.gcr_tog != $past(l_q.gcr_tog))
        else $error("general call reset not applied after ack");
    a_por_ptr: assert property (@(posedge i_scl)
        rst_scl |=> l_q.ptr == `DCI_PTR_RESET && l_q.st == dci_pkg::ST_IDLE)
        else $error("pointer not cleared by reset");
    // system-domain checks
    a_wr_strobe_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_wr_strobe |=> !o_wr_strobe)
        else $error("write strobe longer than one cycle");
    a_hs_exit_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (ev_s[5] != s_q.stop_p && ev_s[6] == s_q.hs_p) |=> !o_hs_mode)
        else $error("high-speed mode kept after stop");

    c_write_word: cover property (@(posedge i_clk_sys) o_wr_strobe);
    c_hs_entry: cover property (@(posedge i_clk_sys) $rose(o_hs_mode));
    c_gc_reset: cover property (@(posedge i_clk_sys) o_gc_reset);
    c_read_byte: cover property (@(posedge i_scl) l_q.st == dci_pkg::ST_RD
        && l_q.cnt == `DCI_BIT_ACK && !i_sda);
endmodule // dci_i2c_front

// file: dci_host.sv
// behavioural i2c host for the dac command front end
`timescale 1ns/100ps
module dci_host (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // clock stands high outside frames
    task automatic bit_io(input logic b, output logic r);
        o_scl = 1'b0;
        #8 o_sda_low = ~b;
        #8 o_scl = 1'b1;
        r = i_sda;
        #16;
    endtask
    // also serves as repeated start
    task automatic start();
        o_scl = 1'b0;
        #8 o_sda_low = 1'b0;
        #8 o_scl = 1'b1;
        #8 o_sda_low = 1'b1;
        #8;
    endtask
    task automatic stop();
        o_scl = 1'b0;
        #8 o_sda_low = 1'b1;
        #8 o_scl = 1'b1;
        #8 o_sda_low = 1'b0;
        #8;
    endtask
    // eight data bits then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ak,
                        output logic [7:0] rx, output logic ra);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ak, ra);
    endtask
    task automatic clocks(input int n);
        logic d;
        repeat (n) bit_io(1'b1, d);
    endtask
endmodule // dci_host

// file: dci_tb.sv
// self-checking bench of the dac command front end
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ph = 1'b0, pl = 1'b0, nv = 1'b0;
    logic [4:0]  up = 5'h00;
    logic        scl, sda_low, sda_out, oe_n, sda, stb, gcr, gcw, hs;
    logic [4:0]  wa, ptr, a;
    logic [15:0] wd, rd, w;
    logic [7:0]  rx;
    logic        ra;
    logic [6:0]  adr;
    logic [31:0] r;
    int          error_cnt = 0, total_checks = 0, n_wr = 0, n_gr = 0, n_gw = 0;
    // pull-up: wire low when either party pulls
    assign sda = ~sda_low & (oe_n | sda_out);
    assign rd = {3'h5, ptr, 8'hC3};
    initial forever #50 clk = ~clk;
    dci_host host_u (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    dci_i2c_front dut_u (.i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_address_select_pin_high(ph),
        .i_address_select_pin_low(pl), .i_nv_variant(nv),
        .i_upper_client_address_bits(up), .i_rd_data(rd), .o_wr_strobe(stb),
        .o_wr_addr(wa), .o_wr_data(wd), .o_gc_reset(gcr), .o_gc_wake(gcw),
        .o_hs_mode(hs), .o_mem_ptr(ptr));
    always @(posedge clk) begin
        if (stb === 1'b1) n_wr++;
        if (gcr === 1'b1) n_gr++;
        if (gcw === 1'b1) n_gw++;
    end
    function automatic logic [15:0] rdw(input logic [4:0] p);
        return {3'h5, p, 8'hC3};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic snd(input logic [7:0] b, input logic e);
        host_u.xfer(b, 1'b1, rx, ra);
        chk({15'h0000, ra}, {15'h0000, e});
    endtask
    task automatic settle();
        repeat (10) @(negedge clk);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    initial begin
        r = $urandom(32'h1CA5);
        host_u.clocks(4);
        repeat (4) @(negedge clk);
        rst = 1'b0;
        host_u.clocks(4);
        chk(ptr, 16'h0000);
        chk(hs, 16'h0000);
        chk({15'h0000, sda_out}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            r = $urandom;
            // upper bits kept off 0000x, which the client decodes as general call or hs code
            {ph, pl, up} = r[6:0] | 7'h10;
            nv = k[0];
            adr = nv ? {up, ph, pl} : {5'h18, ph, pl};
            host_u.start();
            snd({adr, 1'b0}, 1'b0);
            // back-to-back words without stop
            for (int j = 0; j < 2; j++) begin
                r = $urandom;
                a = {1'b0, r[19:16]};
                w = r[15:0];
                snd({a, 3'b000}, 1'b0);
                snd(w[15:8], 1'b0);
                snd(w[7:0], 1'b0);
                settle();
                chk(wa, a);
                chk(wd, w);
            end
            host_u.stop();
            settle();
            chk(ptr, a);
        end
        chk(n_wr, 8);
        host_u.start();
        snd({adr ^ 7'h01, 1'b0}, 1'b1);
        host_u.stop();
        // type 01, type 10, unimplemented location
        for (int k = 0; k < 3; k++) begin
            host_u.start();
            snd({adr, 1'b0}, 1'b0);
            snd(k == 0 ? 8'h0A : k == 1 ? 8'h14 : 8'h80, 1'b1);
            snd(8'h55, 1'b1);
            host_u.stop();
        end
        host_u.start();
        snd({adr, 1'b0}, 1'b0);
        snd(8'h18, 1'b0);
        snd(8'hA5, 1'b0);
        host_u.clocks(4);
        host_u.stop();
        settle();
        chk(n_wr, 8);
        host_u.start();
        snd({5'h01, r[2:0]}, 1'b1);
        settle();
        chk(hs, 16'h0001);
        host_u.start();
        snd({adr, 1'b0}, 1'b0);
        settle();
        chk(hs, 16'h0001);
        host_u.stop();
        settle();
        chk(hs, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            host_u.start();
            snd(8'h00, 1'b0);
            snd(k == 0 ? 8'h06 : k == 1 ? 8'h0A : 8'h07, k == 2);
            host_u.stop();
            settle();
            chk(n_gr, 1);
            chk(n_gw, k > 0);
        end
        a = {1'b0, r[23:20]};
        host_u.start();
        snd({adr, 1'b0}, 1'b0);
        snd({a, 3'b110}, 1'b0);
        settle();
        host_u.start();
        snd({adr, 1'b1}, 1'b0);
        host_u.xfer(8'hFF, 1'b0, rx, ra);
        w[15:8] = rx;
        host_u.xfer(8'hFF, 1'b1, rx, ra);
        w[7:0] = rx;
        host_u.stop();
        chk(w, rdw(a));
        close_out();
    end
endmodule // testbench
